// ---- src/nibble_cpu_opcode_decode.sv ----
// Decode and execute of the one-word control, memory and accumulator opcodes.
// Assumes the core presents one word per instrValid pulse while busy is low,
// and that memory read data returns later with a one-cycle ioReadValid.
`timescale 1ns/1ns
module nibble_cpu_opcode_decode (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    // Instruction from the core
    input wire logic instrValid,
    input wire logic [3:0] opcodeHighNibble,
    input wire logic [3:0] opcodeLowNibble,
    // Interrupt entry from the core
    input wire logic irqAccept,
    input wire logic [11:0] pcCurrent,
    // Test pin, asynchronous
    input wire logic testPin,
    // Index register access from the core
    input wire logic regWriteEn,
    input wire logic [3:0] regWriteIdx,
    input wire logic [3:0] regWriteData,
    input wire logic [3:0] regReadIdx,
    output logic [3:0] regReadData,
    // Memory read return
    input wire logic ioReadValid,
    input wire logic [3:0] ioReadData,
    // Memory strobes
    output logic ioWrite,
    output logic ioRead,
    output logic [3:0] ioKind,
    output logic [3:0] ioWriteData,
    output logic [1:0] ioStatusIdx,
    output logic [7:0] srcAddr,
    // Processor state
    output logic [3:0] acc,
    output logic carry,
    output logic [2:0] cmdLine,
    output logic [1:0] romCommandLine,
    output logic regBankAlt,
    output logic irqEnable,
    output logic halted,
    output logic dataBufInhibit,
    output logic busy,
    // Program counter control
    output logic pcLoad,
    output logic [11:0] pcRestore,
    output logic jumpValid,
    output logic jumpTaken
);

    // Maps a register field onto the file, honouring the bank
    function automatic logic [4:0] physIndex(input logic [3:0] idx,
                                             input logic alt);
        // Alternate bank replaces only registers 0-7
        if (alt && !idx[3]) begin
            physIndex = nibble_cpu_pkg::ALT_BASE + {2'b00, idx[2:0]};
        end else begin
            physIndex = {1'b0, idx};
        end
    endfunction

    nibble_cpu_pkg::state_t state;
    nibble_cpu_pkg::state_t next_state;
    logic [3:0] regFile [0:nibble_cpu_pkg::REG_DEPTH-1];
    logic testSync1;
    logic testSync2;
    logic [3:0] pendingOp;
    logic [11:0] savedPc;
    logic [7:0] savedSrc;
    logic exec;
    logic isCtrl;
    logic isIo;
    logic isAcc;
    logic [4:0] sum;
    logic [4:0] readSum;
    logic condMet;
    logic [3:0] pairHigh;
    logic [3:0] pairLow;

    // Decode qualifiers
    assign exec = instrValid && (state == nibble_cpu_pkg::ST_RUN);
    assign isCtrl = exec && (opcodeHighNibble == nibble_cpu_pkg::GRP_CTRL);
    assign isIo = exec && (opcodeHighNibble == nibble_cpu_pkg::GRP_IO);
    assign isAcc = exec && (opcodeHighNibble == nibble_cpu_pkg::GRP_ACC);

    // Test pin synchroniser
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            testSync1 <= 1'b0;
            testSync2 <= 1'b0;
        end else if (clkEnable) begin
            testSync1 <= testPin;
            testSync2 <= testSync1;
        end
    end

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            nibble_cpu_pkg::ST_RUN: begin
                if (isCtrl && opcodeLowNibble == nibble_cpu_pkg::CT_HALT) begin
                    next_state = nibble_cpu_pkg::ST_HALT;
                end else if (isIo && opcodeLowNibble[3]
                             && opcodeLowNibble != nibble_cpu_pkg::IO_ROM_RD
                             ) begin
                    next_state = nibble_cpu_pkg::ST_READ;
                end else if (isIo
                             && opcodeLowNibble == nibble_cpu_pkg::IO_ROM_RD
                             ) begin
                    next_state = nibble_cpu_pkg::ST_READ;
                end
            end
            nibble_cpu_pkg::ST_READ: begin
                if (ioReadValid) begin
                    next_state = nibble_cpu_pkg::ST_RUN;
                end
            end
            nibble_cpu_pkg::ST_HALT: begin
                // Only an accepted interrupt leaves halt
                if (irqAccept) begin
                    next_state = nibble_cpu_pkg::ST_RUN;
                end
            end
            default: next_state = nibble_cpu_pkg::ST_RUN;
        endcase
    end

    // State and its flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= nibble_cpu_pkg::ST_RUN;
            halted <= 1'b0;
            dataBufInhibit <= 1'b0;
            busy <= 1'b0;
        end else if (clkEnable) begin
            state <= next_state;
            halted <= (next_state == nibble_cpu_pkg::ST_HALT);
            dataBufInhibit <= (next_state == nibble_cpu_pkg::ST_HALT);
            busy <= (next_state != nibble_cpu_pkg::ST_RUN);
        end
    end

    // Index register file
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < nibble_cpu_pkg::REG_DEPTH; i++) begin
                regFile[i] <= 4'h0;
            end
            regReadData <= 4'h0;
        end else if (clkEnable) begin
            if (regWriteEn) begin
                regFile[physIndex(regWriteIdx, regBankAlt)] <= regWriteData;
            end
            regReadData <= regFile[physIndex(regReadIdx, regBankAlt)];
        end
    end

    // pair field picks even and odd register
    assign pairHigh = regFile[physIndex({opcodeLowNibble[3:1], 1'b0},
                                        regBankAlt)];
    assign pairLow = regFile[physIndex({opcodeLowNibble[3:1], 1'b1},
                                       regBankAlt)];

    // Chip-select address, interrupt save and restore
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            srcAddr <= nibble_cpu_pkg::SRC_RESET;
            savedSrc <= nibble_cpu_pkg::SRC_RESET;
            savedPc <= nibble_cpu_pkg::PC_RESET;
            pcRestore <= nibble_cpu_pkg::PC_RESET;
            pcLoad <= 1'b0;
        end else if (clkEnable) begin
            pcLoad <= 1'b0;
            if (irqAccept) begin
                savedPc <= pcCurrent;
                savedSrc <= srcAddr;
            end
            if (exec && opcodeHighNibble == nibble_cpu_pkg::GRP_SRC
                && opcodeLowNibble[0]) begin
                srcAddr <= {pairHigh, pairLow};
            end
            if (isCtrl && opcodeLowNibble == nibble_cpu_pkg::CT_IRET) begin
                srcAddr <= savedSrc;
                pcRestore <= savedPc;
                pcLoad <= 1'b1;
            end
        end
    end

    // Control flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            romCommandLine <= 2'b01;
            regBankAlt <= 1'b0;
            irqEnable <= 1'b0;
            cmdLine <= nibble_cpu_pkg::CMD_RESET;
        end else if (clkEnable) begin
            if (isCtrl) begin
                case (opcodeLowNibble)
                    nibble_cpu_pkg::CT_ROM0: romCommandLine <= 2'b01;
                    nibble_cpu_pkg::CT_ROM1: romCommandLine <= 2'b10;
                    nibble_cpu_pkg::CT_RBANK0: regBankAlt <= 1'b0;
                    nibble_cpu_pkg::CT_RBANK1: regBankAlt <= 1'b1;
                    nibble_cpu_pkg::CT_IEN: irqEnable <= 1'b1;
                    nibble_cpu_pkg::CT_IDIS: irqEnable <= 1'b0;
                    default: ;
                endcase
            end
            if (isAcc && opcodeLowNibble == nibble_cpu_pkg::AC_DCL) begin
                cmdLine <= acc[2:0];
            end
        end
    end

    // Memory strobes and pending read
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ioWrite <= 1'b0;
            ioRead <= 1'b0;
            ioKind <= 4'h0;
            ioWriteData <= 4'h0;
            ioStatusIdx <= 2'h0;
            pendingOp <= 4'h0;
        end else if (clkEnable) begin
            ioWrite <= 1'b0;
            ioRead <= 1'b0;
            if (isIo) begin
                ioKind <= opcodeLowNibble;
                ioStatusIdx <= opcodeLowNibble[1:0];
                pendingOp <= opcodeLowNibble;
                if (!opcodeLowNibble[3]) begin
                    ioWrite <= 1'b1;
                    ioWriteData <= acc;
                end else begin
                    ioRead <= 1'b1;
                end
            end
        end
    end

    // Arithmetic helpers
    assign sum = {1'b0, acc} + 5'h01;
    assign readSum = (pendingOp == nibble_cpu_pkg::IO_SUB)
                   ? {1'b0, acc} + {1'b0, ~ioReadData} + {4'h0, ~carry}
                   : {1'b0, acc} + {1'b0, ioReadData} + {4'h0, carry};

    // Accumulator and carry
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc <= nibble_cpu_pkg::ACC_RESET;
            carry <= 1'b0;
        end else if (clkEnable) begin
            if (state == nibble_cpu_pkg::ST_READ && ioReadValid) begin
                if (pendingOp == nibble_cpu_pkg::IO_SUB
                    || pendingOp == nibble_cpu_pkg::IO_ADD) begin
                    acc <= readSum[3:0];
                    carry <= readSum[4];
                end else begin
                    acc <= ioReadData;
                end
            end else if (isCtrl) begin
                case (opcodeLowNibble)
                    nibble_cpu_pkg::CT_CMDRD: acc <= {1'b0, cmdLine};
                    nibble_cpu_pkg::CT_OR4,
                    nibble_cpu_pkg::CT_OR5: begin
                        acc <= acc | regFile[physIndex(opcodeLowNibble,
                                                       regBankAlt)];
                    end
                    nibble_cpu_pkg::CT_AN6,
                    nibble_cpu_pkg::CT_AN7: begin
                        acc <= acc & regFile[physIndex(opcodeLowNibble,
                                                       regBankAlt)];
                    end
                    default: ;
                endcase
            end else if (isAcc) begin
                case (opcodeLowNibble)
                    nibble_cpu_pkg::AC_CLB: begin
                        acc <= 4'h0;
                        carry <= 1'b0;
                    end
                    nibble_cpu_pkg::AC_CLC: carry <= 1'b0;
                    nibble_cpu_pkg::AC_CMC: carry <= ~carry;
                    nibble_cpu_pkg::AC_STC: carry <= 1'b1;
                    nibble_cpu_pkg::AC_INC: begin
                        acc <= sum[3:0];
                        carry <= sum[4];
                    end
                    nibble_cpu_pkg::AC_CMA: acc <= ~acc;
                    nibble_cpu_pkg::AC_DEC: begin
                        acc <= acc - 4'h1;
                        carry <= (acc != 4'h0);
                    end
                    nibble_cpu_pkg::AC_RAL: {carry, acc} <= {acc, carry};
                    nibble_cpu_pkg::AC_RAR: {acc, carry} <= {carry, acc};
                    nibble_cpu_pkg::AC_TCC: begin
                        acc <= {3'b000, carry};
                        carry <= 1'b0;
                    end
                    nibble_cpu_pkg::AC_TCS: begin
                        acc <= carry ? nibble_cpu_pkg::TCS_CARRY
                                     : nibble_cpu_pkg::TCS_NOCARRY;
                        carry <= 1'b0;
                    end
                    // Decimal adjust, carry only ever set
                    nibble_cpu_pkg::AC_DAA: begin
                        if (carry || acc > nibble_cpu_pkg::DAA_LIMIT) begin
                            acc <= acc + nibble_cpu_pkg::DAA_ADJUST;
                            if (acc > nibble_cpu_pkg::DAA_LIMIT) begin
                                carry <= 1'b1;
                            end
                        end
                    end
                    nibble_cpu_pkg::AC_KBP: begin
                        case (acc)
                            4'h0: acc <= 4'h0;
                            4'h1: acc <= 4'h1;
                            4'h2: acc <= 4'h2;
                            4'h4: acc <= 4'h3;
                            4'h8: acc <= 4'h4;
                            default: acc <= nibble_cpu_pkg::KBP_ERROR;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
    end

    assign condMet = (opcodeLowNibble[nibble_cpu_pkg::JC_ZERO]
                      && acc == 4'h0)
                   || (opcodeLowNibble[nibble_cpu_pkg::JC_CARRY] && carry)
                   || (opcodeLowNibble[nibble_cpu_pkg::JC_TEST]
                       && !testSync2);

    // Jump decision
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            jumpValid <= 1'b0;
            jumpTaken <= 1'b0;
        end else if (clkEnable) begin
            jumpValid <= exec && opcodeHighNibble == nibble_cpu_pkg::GRP_JUMP;
            if (exec && opcodeHighNibble == nibble_cpu_pkg::GRP_JUMP) begin
                jumpTaken <= condMet
                           ^ opcodeLowNibble[nibble_cpu_pkg::JC_INVERT];
            end
        end
    end

endmodule

// ---- src/nibble_cpu_pkg.sv ----
// Constants, opcode encodings and the state type of the nibble decoder.
// Assumes a core that hands over one fetched word at a time.
// Overview of operation
// - Halt opcode freezes the program counter and inhibits data buffers.
// - Interrupt return restores program counter and chip-select address.
// - Command-register read copies the command-line register into accumulator.
// - OR index register 4 or 5 into the accumulator.
// - AND index register 6 or 7 into the accumulator.
// - Bank opcodes make ROM bank 0 or 1 and its command line active.
// - Bank opcodes map index registers 0-7 to primary or alternate bank.
// - Memory input-output acts on the last chip-select address sent.
// - Write accumulator to RAM character, RAM port, ROM port, program memory.
// - Write accumulator into RAM status character 0 to 3.
// - Subtract RAM character with borrow, or add it with carry.
// - Load the selected RAM main character into the accumulator.
// - Load the selected ROM input port into the accumulator.
// - Load RAM status character 0 to 3 into the accumulator.
// - RAM register: 16 main characters by address, 4 status by opcode.
// - Clear both, clear carry, complement carry, set carry.
// - Rotate accumulator with carry left or right by one.
// - Move carry into accumulator, then clear carry.
// - Load subtract-carry transfer value from carry, then clear carry.
// - Convert a one-hot accumulator code into its binary position.
// - Jump condition: invert, accumulator zero, carry set, test input low.
// - Pair field picks one of 8 pairs; register field one of 16.
package nibble_cpu_pkg;
    // Opcode groups (high nibble)
    localparam logic [3:0] GRP_CTRL = 4'h0;
    localparam logic [3:0] GRP_JUMP = 4'h1;
    localparam logic [3:0] GRP_SRC = 4'h2;
    localparam logic [3:0] GRP_IO = 4'hE;
    localparam logic [3:0] GRP_ACC = 4'hF;
    // Control group (low nibble)
    localparam logic [3:0] CT_HALT = 4'h1;
    localparam logic [3:0] CT_IRET = 4'h2;
    localparam logic [3:0] CT_CMDRD = 4'h3;
    localparam logic [3:0] CT_OR4 = 4'h4;
    localparam logic [3:0] CT_OR5 = 4'h5;
    localparam logic [3:0] CT_AN6 = 4'h6;
    localparam logic [3:0] CT_AN7 = 4'h7;
    localparam logic [3:0] CT_ROM0 = 4'h8;
    localparam logic [3:0] CT_ROM1 = 4'h9;
    localparam logic [3:0] CT_RBANK0 = 4'hA;
    localparam logic [3:0] CT_RBANK1 = 4'hB;
    localparam logic [3:0] CT_IEN = 4'hC;
    localparam logic [3:0] CT_IDIS = 4'hD;
    // Input-output group (low nibble)
    localparam logic [3:0] IO_RAM_WR = 4'h0;
    localparam logic [3:0] IO_PORT_WR = 4'h1;
    localparam logic [3:0] IO_ROM_WR = 4'h2;
    localparam logic [3:0] IO_PROG_WR = 4'h3;
    localparam logic [3:0] IO_SUB = 4'h8;
    localparam logic [3:0] IO_RAM_RD = 4'h9;
    localparam logic [3:0] IO_ROM_RD = 4'hA;
    localparam logic [3:0] IO_ADD = 4'hB;
    localparam logic [1:0] IO_STAT_WR = 2'h1;
    localparam logic [1:0] IO_STAT_RD = 2'h3;
    // Accumulator group (low nibble)
    localparam logic [3:0] AC_CLB = 4'h0;
    localparam logic [3:0] AC_CLC = 4'h1;
    localparam logic [3:0] AC_INC = 4'h2;
    localparam logic [3:0] AC_CMC = 4'h3;
    localparam logic [3:0] AC_CMA = 4'h4;
    localparam logic [3:0] AC_RAL = 4'h5;
    localparam logic [3:0] AC_RAR = 4'h6;
    localparam logic [3:0] AC_TCC = 4'h7;
    localparam logic [3:0] AC_DEC = 4'h8;
    localparam logic [3:0] AC_TCS = 4'h9;
    localparam logic [3:0] AC_STC = 4'hA;
    localparam logic [3:0] AC_DAA = 4'hB;
    localparam logic [3:0] AC_KBP = 4'hC;
    localparam logic [3:0] AC_DCL = 4'hD;
    // Values and limits
    localparam logic [3:0] TCS_CARRY = 4'hA;
    localparam logic [3:0] TCS_NOCARRY = 4'h9;
    localparam logic [3:0] DAA_LIMIT = 4'h9;
    localparam logic [3:0] DAA_ADJUST = 4'h6;
    localparam logic [3:0] KBP_ERROR = 4'hF;
    localparam int REG_PRIMARY = 16;
    localparam int REG_DEPTH = 24;
    localparam logic [4:0] ALT_BASE = 5'h10;
    // Jump condition bit positions (first bit is the top bit)
    localparam int JC_INVERT = 3;
    localparam int JC_ZERO = 2;
    localparam int JC_CARRY = 1;
    localparam int JC_TEST = 0;
    // Reset values
    localparam logic [3:0] ACC_RESET = 4'h0;
    localparam logic [2:0] CMD_RESET = 3'h0;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    typedef enum logic [1:0] {ST_RUN, ST_READ, ST_HALT} state_t;
endpackage

// ---- tb/nibble_cpu_opcode_decode_test.sv ----
// Self-checking bench for the nibble decoder and a memory model.
// Assumes the package, decoder, checker and model compile first.
`timescale 1ns/1ns
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module nibble_cpu_opcode_decode_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEnable = 1'b1;
    logic instrValid = 1'b0;
    logic irqAccept = 1'b0;
    logic testPin = 1'b1;
    logic regWriteEn = 1'b0;
    logic [3:0] opcodeHighNibble = 4'h0;
    logic [3:0] opcodeLowNibble = 4'h0;
    logic [11:0] pcCurrent = 12'h000;
    logic [3:0] regWriteIdx = 4'h0;
    logic [3:0] regWriteData = 4'h0;
    logic [3:0] regReadIdx = 4'h0;
    logic [3:0] lag = 4'h0;
    logic [3:0] romIn = 4'h0;
    logic [3:0] regReadData, ioKind, ioWriteData, acc, ioReadData;
    logic [1:0] ioStatusIdx, romCommandLine;
    logic [7:0] srcAddr, srcS;
    logic [2:0] cmdLine;
    logic [11:0] pcRestore, pcS;
    logic ioReadValid, ioWrite, ioRead, carry, regBankAlt, irqEnable;
    logic halted, dataBufInhibit, busy, pcLoad, jumpValid, jumpTaken;
    int failures = 0;
    int cmpCount = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_7B61;
    logic [3:0] eAcc = 4'h0, sMain, rv [8], sStat [4];
    logic eCar = 1'b0;
    logic [2:0] eCmd = 3'h0;
    logic [7:0] fOp [4] = '{8'h0C, 8'h09, 8'h0D, 8'h08};
    logic [2:0] fExp [4] = '{3'h3, 3'h5, 3'h4, 3'h2};
    logic [7:0] pool [34] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
        8'hE6, 8'hE7, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6,
        8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'hFC, 8'hFD, 8'hE8, 8'hE9, 8'hEA,
        8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07};
    nibble_cpu_opcode_decode u_dut (.*);
    nibble_mem_model u_mem (.*);
    always #50 clk = ~clk;
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected {carry, acc} after one word
    function automatic logic [4:0] step(logic [7:0] op, logic [3:0] a,
            logic c, logic [3:0] m);
        logic [4:0] s;
        s = {c, a};
        case (op)
            8'hF0: s = 5'h00;
            8'hF1: s[4] = 1'b0;
            8'hF2: s = {1'b0, a} + 5'h01;
            8'hF3: s[4] = ~c;
            8'hF4: s[3:0] = ~a;
            8'hF5: s = {a, c};
            8'hF6: s = {a[0], c, a[3:1]};
            8'hF7: s = {4'h0, c};
            8'hF8: s = {a != 4'h0, a - 4'h1};
            8'hF9: s = {1'b0, c ? 4'hA : 4'h9};
            8'hFA: s[4] = 1'b1;
            8'hFC: s[3:0] = (a < 4'h3) ? a : (a == 4'h4) ? 4'h3
                : (a == 4'h8) ? 4'h4 : 4'hF;
            8'hE8: s = {1'b0, a} + {1'b0, ~m} + {4'h0, ~c};
            8'hEB: s = {1'b0, a} + {1'b0, m} + {4'h0, c};
            8'hE9, 8'hEA, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'h03: s[3:0] = m;
            8'h04, 8'h05: s[3:0] = a | m;
            8'h06, 8'h07: s[3:0] = a & m;
            default: s = {c, a};
        endcase
        return s;
    endfunction
    // One word through the decoder, checked at its ports
    task automatic do_op(input logic [7:0] op);
        logic [4:0] r;
        logic [3:0] m;
        logic jt;
        int n;
        @(negedge clk); // Idle cycle keeps strobes apart
        romIn = 4'(rnd());
        lag = 4'(rnd());
        m = (op == 8'hEA) ? romIn : (op[7:4] != 4'hE) ? rv[op[2:0]]
            : op[2] ? sStat[op[1:0]] : sMain;
        if (op == 8'h03) m = {1'b0, eCmd};
        r = step(op, eAcc, eCar, m);
        jt = op[3] ^ ((op[2] && eAcc == 4'h0) || (op[1] && eCar)
            || (op[0] && !testPin));
        {opcodeHighNibble, opcodeLowNibble} = op;
        instrValid = 1'b1;
        @(negedge clk);
        instrValid = 1'b0;
        if (op[7:3] == 5'h1C) `CHK({ioWrite, ioWriteData, ioKind,
            ioStatusIdx}, {1'b1, eAcc, op[3:0], op[1:0]})
        if (op[7:4] == 4'h1) `CHK({jumpValid, jumpTaken}, {1'b1, jt})
        if (op == 8'h02) `CHK({pcLoad, pcRestore, srcAddr},
            {1'b1, pcS, srcS})
        if (op == 8'hE0) sMain = eAcc;
        if (op[7:2] == 6'h39) sStat[op[1:0]] = eAcc;
        if (op == 8'hFD) eCmd = eAcc[2:0];
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        {eCar, eAcc} = r;
        `CHK({carry, acc, cmdLine}, {r, eCmd})
    endtask
    task automatic setreg(input logic [3:0] i, input logic [3:0] v);
        @(negedge clk); // Idle cycle keeps strobes apart
        regWriteEn = 1'b1;
        regWriteIdx = i;
        regWriteData = v;
        @(negedge clk);
        regWriteEn = 1'b0;
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rv[i] = 4'(rnd());
            setreg(4'(i), rv[i]);
        end
        // Select pair 0, then each of the 34 pool codes and a random mix
        do_op(8'h21);
        `CHK(srcAddr, {rv[0], rv[1]})
        for (int i = 0; i < 34; i++) do_op(pool[i]);
        repeat (300) do_op(pool[rnd() % 34]);
        foreach (fOp[i]) begin
            do_op(fOp[i]);
            `CHK({romCommandLine, irqEnable}, fExp[i])
        end
        // Alternate bank hides primary register 4
        do_op(8'h0B);
        setreg(4'h4, ~rv[4]);
        regReadIdx = 4'h4;
        @(negedge clk);
        `CHK({regBankAlt, regReadData}, {1'b1, ~rv[4]})
        do_op(8'h0A);
        @(negedge clk);
        `CHK({regBankAlt, regReadData}, {1'b0, rv[4]})
        // Every condition code with a random test level
        for (int i = 0; i < 16; i++) begin
            do_op(pool[rnd() % 34]);
            testPin = seed[7];
            repeat (3) @(negedge clk);
            do_op({4'h1, 4'(i)});
        end
        // Halt, refused word, wake, then return
        srcS = {rv[0], rv[1]};
        pcS = 12'(rnd());
        do_op(8'h01);
        `CHK({halted, dataBufInhibit, busy}, 3'h7)
        {opcodeHighNibble, opcodeLowNibble} = 8'hF4;
        instrValid = 1'b1;
        @(negedge clk);
        instrValid = 1'b0;
        irqAccept = 1'b1;
        pcCurrent = pcS;
        @(negedge clk);
        irqAccept = 1'b0;
        `CHK({halted, acc}, {1'b0, eAcc})
        do_op(8'h23);
        do_op(8'h02);
        tally_and_finish();
    end
endmodule

// ---- tb/nibble_decode_checker_assertions.sv ----
// Checker for the nibble decoder, watching its ports only.
// Assumes clkEnable is held high while it runs.
`timescale 1ns/1ns
module nibble_decode_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Instruction side
    input wire logic instrValid,
    input wire logic [3:0] opcodeHighNibble,
    input wire logic [3:0] opcodeLowNibble,
    input wire logic irqAccept,
    // Watched outputs
    input wire logic busy,
    input wire logic [3:0] acc,
    input wire logic carry,
    input wire logic [2:0] cmdLine,
    input wire logic halted,
    input wire logic dataBufInhibit,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [3:0] ioKind,
    input wire logic [3:0] ioWriteData
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic [7:0] op;
    // Accepted word and its full code
    assign take = instrValid && !busy;
    assign op = {opcodeHighNibble, opcodeLowNibble};
    a_halt_entry: assert property (take && op == 8'h01
        |=> halted && dataBufInhibit && busy) else $error("no halt");
    a_halt_hold: assert property (halted && !irqAccept
        |=> halted) else $error("halt left early");
    a_clear_both: assert property (take && op == 8'hF0
        |=> acc == 4'h0 && !carry) else $error("clear failed");
    a_carry_flip: assert property (take && op == 8'hF3
        |=> carry != $past(carry)) else $error("carry not flipped");
    a_rotate_left: assert property (take && op == 8'hF5
        |=> {carry, acc} == {$past(acc), $past(carry)}) else $error("ral");
    a_carry_xfer: assert property (take && op == 8'hF9
        |=> !carry && acc == ($past(carry) ? 4'hA : 4'h9)) else $error("tcs");
    a_cmd_read: assert property (take && op == 8'h03
        |=> acc == {1'b0, $past(cmdLine)}) else $error("cmd read");
    a_write_strobe: assert property (take && op[7:3] == 5'h1C
        |=> ioWrite && ioKind == $past(opcodeLowNibble)
        && ioWriteData == $past(acc)) else $error("write strobe");
    a_read_wait: assert property (take && op[7:3] == 5'h1D
        |=> ioRead && busy) else $error("read request");
    c_halt: cover property (take && op == 8'h01);
    c_read: cover property (ioRead);
    c_wake: cover property (halted && irqAccept);
endmodule
bind nibble_cpu_opcode_decode nibble_decode_checker u_chk (.*);

// ---- tb/nibble_mem_model.sv ----
// Behavioural RAM and ROM chips on the far side of the decoder.
// Assumes srcAddr holds the last chip-select address.
`timescale 1ns/1ns
module nibble_mem_model (
    // Clock and answer pace
    input wire logic clk,
    input wire logic [3:0] lag,
    input wire logic [3:0] romIn,
    // Strobes from the decoder
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [3:0] ioKind,
    input wire logic [3:0] ioWriteData,
    input wire logic [1:0] ioStatusIdx,
    input wire logic [7:0] srcAddr,
    // Read return
    output logic ioReadValid = 1'b0,
    output logic [3:0] ioReadData = 4'h5
);
    logic [3:0] mainMem [256];
    logic [3:0] statMem [16][4];
    logic [3:0] cnt = 4'h0;
    logic [3:0] kind = 4'h0;
    logic pend = 1'b0;
    // Writes land at the selected place
    always @(posedge clk) begin
        if (ioWrite && ioKind == 4'h0) mainMem[srcAddr] <= ioWriteData;
        if (ioWrite && ioKind[3:2] == 2'h1)
            statMem[srcAddr[7:4]][ioStatusIdx] <= ioWriteData;
    end
    always @(posedge clk) begin
        ioReadValid <= 1'b0;
        ioReadData <= ~ioReadData; // Stale data never looks valid
        if (ioRead) begin
            pend <= 1'b1;
            cnt <= lag;
            kind <= ioKind;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            pend <= 1'b0;
            ioReadValid <= 1'b1;
            ioReadData <= (kind == 4'hA) ? romIn : kind[2]
                ? statMem[srcAddr[7:4]][kind[1:0]] : mainMem[srcAddr];
        end
    end
endmodule
